// >>> src/fbcmd_pkg.sv
package fbcmd_pkg;

    // Exchange word layout.
    localparam int WORD_W = 32;
    localparam int TOGGLE_BIT = 0;
    localparam int RDSEL_LO = 1;
    localparam int RDSEL_HI = 5;
    localparam int CMD_LO = 6;
    localparam int CMD_HI = 10;
    localparam int EXP_LO = 16;
    localparam int EXP_HI = 23;
    localparam int VALUE_HI = 15;
    localparam int ERR_LO = 11;
    localparam int ERR_HI = 15;

    // Read data selection codes.
    localparam logic [4:0] RD_ACTUAL = 5'h00;
    localparam logic [4:0] RD_GROSS = 5'h01;
    localparam logic [4:0] RD_TARE = 5'h02;
    localparam logic [4:0] RD_CAL = 5'h03;
    localparam logic [4:0] RD_EXPANDED = 5'h1f;

    // Write command codes.
    localparam logic [4:0] CMD_ZERO_ADJ = 5'h01;
    localparam logic [4:0] CMD_SPAN_ADJ = 5'h02;
    localparam logic [4:0] CMD_EXPANDED = 5'h1f;

    // Expanded command codes with their parameter slots.
    localparam logic [7:0] EXP_FILTER = 8'h40;
    localparam logic [7:0] EXP_ZERO_RANGE = 8'h42;
    localparam logic [7:0] EXP_MOTION = 8'h45;
    localparam logic [7:0] EXP_PREACT = 8'h62;
    localparam logic [7:0] EXP_END_IND = 8'h67;
    localparam logic [7:0] EXP_MAX_FILL = 8'h69;
    localparam int PARAM_DEPTH = 8;
    localparam int PARAM_AW = 3;
    localparam logic [2:0] SLOT_FILTER = 3'h0;
    localparam logic [2:0] SLOT_ZERO_RANGE = 3'h1;
    localparam logic [2:0] SLOT_MOTION = 3'h2;
    localparam logic [2:0] SLOT_PREACT = 3'h3;
    localparam logic [2:0] SLOT_END_IND = 3'h4;
    localparam logic [2:0] SLOT_MAX_FILL = 3'h5;

    // Parameter values after reset, one per slot.
    localparam logic [PARAM_DEPTH*WORD_W-1:0] PARAM_RESET = {
        32'h0, 32'h0, 32'h0000_2710, 32'h0000_0001,
        32'h0000_0001, 32'h0000_0001, 32'h0000_0002, 32'h0000_0003};

    // Calibration status low byte values.
    localparam logic [7:0] CAL_ST_READY = 8'h01;
    localparam logic [7:0] CAL_ST_ZERO = 8'h03;
    localparam logic [7:0] CAL_ST_SPAN = 8'h04;
    localparam logic [7:0] CAL_ST_FAIL = 8'h09;

    // Software register offsets.
    localparam logic [7:0] REG_IRQ_STAT = 8'h00;
    localparam logic [7:0] REG_IRQ_MASK = 8'h04;
    localparam logic [7:0] REG_CAL_STAT = 8'h08;
    localparam logic [7:0] REG_LAST_CMD = 8'h0c;
    localparam logic [7:0] REG_PARAM_SEL = 8'h10;
    localparam logic [7:0] REG_PARAM_DATA = 8'h14;

    // Interrupt status bits.
    localparam int IRQ_W = 4;
    localparam int IRQ_PARAM = 0;
    localparam int IRQ_CAL_DONE = 1;
    localparam int IRQ_CAL_FAIL = 2;
    localparam int IRQ_IGNORED = 3;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 4'h0;

    // Cycles after reset release before the toggle bit is trusted.
    localparam logic [1:0] PRIME_CYCLES = 2'h3;

    typedef enum logic [3:0] {
        CAL_READY = 4'b0001,
        CAL_ZERO = 4'b0010,
        CAL_SPAN = 4'b0100,
        CAL_FAIL = 4'b1000
    } cal_state_e;

    typedef struct packed {
        logic [WORD_W-1:0] first_exchange_word;
        logic [WORD_W-1:0] second_exchange_word;
    } exch_s;

    typedef struct packed {
        logic [7:0] addr;
        logic [WORD_W-1:0] wdata;
        logic wr;
        logic rd;
    } sw_req_s;

    typedef struct packed {
        logic zero_start;
        logic span_start;
        logic [WORD_W-1:0] test_weight;
    } cal_req_s;

endpackage

// >>> src/param_store.sv
`timescale 1ns/1ps
// Small parameter memory: one write port, two read ports with registered data.
module param_store #(
    parameter int DEPTH = fbcmd_pkg::PARAM_DEPTH,
    parameter int AW = fbcmd_pkg::PARAM_AW,
    parameter int W = fbcmd_pkg::WORD_W
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic we_i,
    input wire logic [AW-1:0] waddr_i,
    input wire logic [W-1:0] wdata_i,
    input wire logic [AW-1:0] raddr_a_i,
    output logic [W-1:0] rdata_a_o,
    input wire logic [AW-1:0] raddr_b_i,
    output logic [W-1:0] rdata_b_o
);
    import fbcmd_pkg::*;

    logic [W-1:0] mem_r [DEPTH];

    // Contents come up with defined values so the filling logic never sees junk.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_r[i] <= PARAM_RESET[i*W +: W];
            end
        end else if (we_i) begin
            mem_r[waddr_i] <= wdata_i;
        end
    end

    // Both read ports are registered.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rdata_a_o <= '0;
            rdata_b_o <= '0;
        end else begin
            rdata_a_o <= mem_r[raddr_a_i];
            rdata_b_o <= mem_r[raddr_b_i];
        end
    end
endmodule

// >>> src/fieldbus_param_cal.sv
`timescale 1ns/1ps
module fieldbus_param_cal (
    input wire logic clk_i,
    input wire logic nrst_i,
    input fbcmd_pkg::exch_s exch_in_i,
    output fbcmd_pkg::exch_s exch_out_o,
    input wire logic [31:0] weight_actual_i,
    input wire logic [31:0] weight_gross_i,
    input wire logic [31:0] weight_tare_i,
    input wire logic [4:0] weigh_err_i,
    output fbcmd_pkg::cal_req_s cal_req_o,
    input wire logic cal_done_i,
    input wire logic cal_fail_i,
    input wire logic [7:0] cal_err_code_i,
    input fbcmd_pkg::sw_req_s sw_req_i,
    output logic [31:0] sw_rdata_o,
    output logic irq_o
);
    import fbcmd_pkg::*;

    // Maps an expanded code to its parameter slot; bit 3 flags a code in use.
    function automatic logic [3:0] exp_slot(input logic [7:0] code);
        logic [3:0] res;
        res = 4'h0;
        if (code == EXP_FILTER) begin
            res = {1'b1, SLOT_FILTER};
        end else if (code == EXP_ZERO_RANGE) begin
            res = {1'b1, SLOT_ZERO_RANGE};
        end else if (code == EXP_MOTION) begin
            res = {1'b1, SLOT_MOTION};
        end else if (code == EXP_PREACT) begin
            res = {1'b1, SLOT_PREACT};
        end else if (code == EXP_END_IND) begin
            res = {1'b1, SLOT_END_IND};
        end else if (code == EXP_MAX_FILL) begin
            res = {1'b1, SLOT_MAX_FILL};
        end
        return res;
    endfunction

    exch_s sync1_r;
    exch_s sync2_r;
    logic tog_seen_r;
    logic [1:0] prime_r;
    logic cmd_evt;
    logic [4:0] cmd_code;
    logic [7:0] exp_code;
    logic [3:0] wr_slot;
    logic [3:0] rd_slot;
    logic param_we;
    logic ignored_evt;
    logic [31:0] param_fb_rdata;
    logic [31:0] param_sw_rdata;
    cal_state_e cal_state_r;
    cal_state_e cal_state_nxt;
    logic [7:0] cal_err_r;
    logic [7:0] cal_low;
    logic [31:0] cal_word;
    logic [IRQ_W-1:0] irq_stat_r;
    logic [IRQ_W-1:0] irq_mask_r;
    logic [IRQ_W-1:0] irq_set;
    logic [15:0] last_cmd_r;
    logic [PARAM_AW-1:0] param_sel_r;
    logic [PARAM_AW-1:0] param_raddr_b;
    logic cal_ok_evt;
    logic cal_fail_evt;

    // Both PLC words come from the fieldbus side, so they pass two stages first.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= exch_in_i;
            sync2_r <= sync1_r;
        end
    end

    // The toggle is only tracked, not executed, until the synchroniser holds
    // real pin data; a PLC that leaves the bit high across reset runs nothing.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            prime_r <= 2'h0;
            tog_seen_r <= 1'b0;
        end else begin
            if (prime_r != PRIME_CYCLES) begin
                prime_r <= prime_r + 2'h1;
            end
            tog_seen_r <= sync2_r.second_exchange_word[TOGGLE_BIT];
        end
    end

    // A command exists for exactly one cycle per level change of the apply bit.
    assign cmd_evt = (prime_r == PRIME_CYCLES) &&
                     (sync2_r.second_exchange_word[TOGGLE_BIT] != tog_seen_r);
    assign cmd_code = sync2_r.second_exchange_word[CMD_HI:CMD_LO];
    assign exp_code = sync2_r.first_exchange_word[EXP_HI:EXP_LO];
    assign wr_slot = exp_slot(exp_code);
    assign rd_slot = exp_slot(exp_code);

    // Parameter is written only on the apply edge, and only for codes in use.
    assign param_we = cmd_evt && (cmd_code == CMD_EXPANDED) && wr_slot[3];
    // A refused command still raises a flag, so software can see that it was dropped.
    assign ignored_evt = cmd_evt && !param_we && !(cal_state_r == CAL_READY &&
                         (cmd_code == CMD_ZERO_ADJ || cmd_code == CMD_SPAN_ADJ));

    // A slot select written just before a data read must already steer the port,
    // or back-to-back software accesses would return the previous slot.
    assign param_raddr_b = (sw_req_i.wr && sw_req_i.addr == REG_PARAM_SEL) ?
                           sw_req_i.wdata[PARAM_AW-1:0] : param_sel_r;

    param_store #(
        .DEPTH(PARAM_DEPTH),
        .AW(PARAM_AW),
        .W(WORD_W)
    ) u_params (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .we_i(param_we),
        .waddr_i(wr_slot[2:0]),
        .wdata_i({16'h0, sync2_r.first_exchange_word[VALUE_HI:0]}),
        .raddr_a_i(rd_slot[2:0]),
        .rdata_a_o(param_fb_rdata),
        .raddr_b_i(param_raddr_b),
        .rdata_b_o(param_sw_rdata)
    );

    // Calibration sequencer; new calibration commands are refused while it is busy.
    always_comb begin
        cal_state_nxt = cal_state_r;
        case (cal_state_r)
            CAL_READY: begin
                if (cmd_evt && cmd_code == CMD_ZERO_ADJ) begin
                    cal_state_nxt = CAL_ZERO;
                end else if (cmd_evt && cmd_code == CMD_SPAN_ADJ) begin
                    cal_state_nxt = CAL_SPAN;
                end
            end
            CAL_ZERO, CAL_SPAN: begin
                if (cal_fail_i) begin
                    cal_state_nxt = CAL_FAIL;
                end else if (cal_done_i) begin
                    cal_state_nxt = CAL_READY;
                end
            end
            CAL_FAIL: begin
                if (cmd_evt) begin
                    cal_state_nxt = CAL_READY;
                end
            end
            default: cal_state_nxt = CAL_READY;
        endcase
    end

    // State register of the calibration sequencer.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cal_state_r <= CAL_READY;
        end else begin
            cal_state_r <= cal_state_nxt;
        end
    end

    // Done and fail are only heard while a calibration runs; stray pulses are dropped.
    assign cal_ok_evt = (cal_state_r == CAL_ZERO || cal_state_r == CAL_SPAN) &&
                        !cal_fail_i && cal_done_i;
    assign cal_fail_evt = (cal_state_r == CAL_ZERO || cal_state_r == CAL_SPAN) && cal_fail_i;

    // Error code is captured at failure and cleared on the next start.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cal_err_r <= 8'h0;
        end else if (cal_fail_evt) begin
            cal_err_r <= cal_err_code_i;
        end else if (cal_state_r == CAL_READY && cal_state_nxt != CAL_READY) begin
            cal_err_r <= 8'h0;
        end
    end

    // Start pulses go out in the cycle after acceptance; test weight is held.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cal_req_o <= '0;
        end else begin
            cal_req_o.zero_start <= (cal_state_r == CAL_READY) &&
                                    (cal_state_nxt == CAL_ZERO);
            cal_req_o.span_start <= (cal_state_r == CAL_READY) &&
                                    (cal_state_nxt == CAL_SPAN);
            if (cal_state_r == CAL_READY && cal_state_nxt == CAL_SPAN) begin
                cal_req_o.test_weight <= sync2_r.first_exchange_word;
            end
        end
    end

    // Status low byte follows the sequencer state directly.
    always_comb begin
        case (cal_state_r)
            CAL_ZERO: cal_low = CAL_ST_ZERO;
            CAL_SPAN: cal_low = CAL_ST_SPAN;
            CAL_FAIL: cal_low = CAL_ST_FAIL;
            default: cal_low = CAL_ST_READY;
        endcase
    end
    assign cal_word = {16'h0, cal_err_r, cal_low};

    // Words back to the PLC. Parameter reads lag one cycle behind the memory.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            exch_out_o <= '0;
        end else begin
            case (sync2_r.second_exchange_word[RDSEL_HI:RDSEL_LO])
                RD_ACTUAL: exch_out_o.first_exchange_word <= weight_actual_i;
                RD_GROSS: exch_out_o.first_exchange_word <= weight_gross_i;
                RD_TARE: exch_out_o.first_exchange_word <= weight_tare_i;
                RD_CAL: exch_out_o.first_exchange_word <= cal_word;
                RD_EXPANDED: exch_out_o.first_exchange_word <= param_fb_rdata;
                default: exch_out_o.first_exchange_word <= 32'h0;
            endcase
            // Error bits let the PLC reject weights; bit 0 echoes the last apply.
            exch_out_o.second_exchange_word <= {16'h0, weigh_err_i, 10'h0, tog_seen_r};
        end
    end

    // Interrupt sources in the bit order of the status register.
    assign irq_set = {ignored_evt, cal_fail_evt, cal_ok_evt, param_we};

    // Sticky status cleared by reading it; a new event in the same cycle wins.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            irq_stat_r <= '0;
        end else if (sw_req_i.rd && sw_req_i.addr == REG_IRQ_STAT) begin
            irq_stat_r <= irq_set;
        end else begin
            irq_stat_r <= irq_stat_r | irq_set;
        end
    end

    assign irq_o = |(irq_stat_r & irq_mask_r);

    // Software writable registers.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            irq_mask_r <= IRQ_MASK_RESET;
            param_sel_r <= '0;
        end else if (sw_req_i.wr) begin
            if (sw_req_i.addr == REG_IRQ_MASK) begin
                irq_mask_r <= sw_req_i.wdata[IRQ_W-1:0];
            end else if (sw_req_i.addr == REG_PARAM_SEL) begin
                param_sel_r <= sw_req_i.wdata[PARAM_AW-1:0];
            end
        end
    end

    // Record of the last applied command, executed or refused, for the instrument processor.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            last_cmd_r <= 16'h0;
        end else if (cmd_evt) begin
            last_cmd_r <= {exp_code, 3'h0, cmd_code};
        end
    end

    // Read data stand in the cycle after the strobe only; unmapped reads zero.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sw_rdata_o <= 32'h0;
        end else if (!sw_req_i.rd) begin
            sw_rdata_o <= 32'h0;
        end else if (sw_req_i.addr == REG_IRQ_STAT) begin
            sw_rdata_o <= {28'h0, irq_stat_r};
        end else if (sw_req_i.addr == REG_IRQ_MASK) begin
            sw_rdata_o <= {28'h0, irq_mask_r};
        end else if (sw_req_i.addr == REG_CAL_STAT) begin
            sw_rdata_o <= cal_word;
        end else if (sw_req_i.addr == REG_LAST_CMD) begin
            sw_rdata_o <= {16'h0, last_cmd_r};
        end else if (sw_req_i.addr == REG_PARAM_SEL) begin
            sw_rdata_o <= {29'h0, param_sel_r};
        end else if (sw_req_i.addr == REG_PARAM_DATA) begin
            sw_rdata_o <= param_sw_rdata;
        end else begin
            sw_rdata_o <= 32'h0;
        end
    end
endmodule

// >>> dv/fbcmd_sva.sv
`timescale 1ns/1ps
// Pin-level checks of the command interpreter, bound into the design.
module fbcmd_sva (
    input wire logic clk_i,
    input wire logic nrst_i,
    input fbcmd_pkg::exch_s exch_in_i,
    input fbcmd_pkg::exch_s exch_out_o,
    input wire logic [4:0] weigh_err_i,
    input fbcmd_pkg::cal_req_s cal_req_o,
    input wire logic cal_done_i,
    input wire logic cal_fail_i,
    input fbcmd_pkg::sw_req_s sw_req_i,
    input wire logic [31:0] sw_rdata_o
);
    import fbcmd_pkg::*;
    logic [4:0] rdsel;
    logic [4:0] cmd;
    logic [7:0] lowb;
    logic quiet;
    logic tog;

    // Views of the exchange fields; quiet means the front end is not answering.
    assign rdsel = exch_in_i.second_exchange_word[5:1];
    assign cmd = exch_in_i.second_exchange_word[10:6];
    assign tog = exch_in_i.second_exchange_word[0];
    assign lowb = exch_out_o.first_exchange_word[7:0];
    assign quiet = !cal_done_i && !cal_fail_i;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    rdata_idle_a: assert property (!$past(sw_req_i.rd) |-> sw_rdata_o == 32'h0)
        else $error("read data not zero outside read answer");
    zero_pulse_a: assert property (cal_req_o.zero_start |=> !cal_req_o.zero_start)
        else $error("zero start longer than one cycle");
    zero_cmd_a: assert property (cal_req_o.zero_start |-> cmd == CMD_ZERO_ADJ)
        else $error("zero start without zero command");
    span_cmd_a: assert property (cal_req_o.span_start |-> cmd == CMD_SPAN_ADJ &&
        cal_req_o.test_weight == exch_in_i.first_exchange_word)
        else $error("span start with wrong command or weight");
    err_pass_a: assert property ($stable(weigh_err_i) [*5] |->
        exch_out_o.second_exchange_word[15:11] == weigh_err_i)
        else $error("error bits not reported");
    ack_follow_a: assert property ($changed(tog) |-> ##[1:8]
        exch_out_o.second_exchange_word[0] == tog)
        else $error("toggle not echoed");
    cal_word_a: assert property (rdsel == RD_CAL [*6] |-> lowb inside {8'h01, 8'h03,
        8'h04, 8'h09} && exch_out_o.first_exchange_word[31:16] == 16'h0)
        else $error("calibration status word malformed");
    zero_busy_a: assert property (cal_req_o.zero_start ##0 (rdsel == RD_CAL && quiet) [*5]
        |-> lowb == CAL_ST_ZERO)
        else $error("zero calibration not shown as busy");
    span_busy_a: assert property (cal_req_o.span_start ##0 (rdsel == RD_CAL && quiet) [*5]
        |-> lowb == CAL_ST_SPAN)
        else $error("span calibration not shown as busy");

    zero_seen_c: cover property (cal_req_o.zero_start);
    span_seen_c: cover property (cal_req_o.span_start);
    fail_seen_c: cover property (rdsel == RD_CAL && lowb == CAL_ST_FAIL);
endmodule

bind fieldbus_param_cal fbcmd_sva u_sva (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .exch_in_i(exch_in_i),
    .exch_out_o(exch_out_o),
    .weigh_err_i(weigh_err_i),
    .cal_req_o(cal_req_o),
    .cal_done_i(cal_done_i),
    .cal_fail_i(cal_fail_i),
    .sw_req_i(sw_req_i),
    .sw_rdata_o(sw_rdata_o)
);

// >>> dv/plc_model.sv
`timescale 1ns/1ps
// Cyclic master on the fieldbus side; it holds every word as a level until told otherwise.
module plc_model (
    input wire logic clk_i,
    input fbcmd_pkg::exch_s resp_i,
    output fbcmd_pkg::exch_s req_o
);
    import fbcmd_pkg::*;

    initial begin
        req_o = '0;
    end

    // Value first, code next, toggle last, then wait for the echo of the toggle.
    task automatic apply(input logic [4:0] cmd, input logic [31:0] first);
        int n;
        @(posedge clk_i);
        req_o.first_exchange_word <= first;
        repeat (4) @(posedge clk_i);
        req_o.second_exchange_word[10:6] <= cmd;
        repeat (4) @(posedge clk_i);
        req_o.second_exchange_word[0] <= ~req_o.second_exchange_word[0];
        @(posedge clk_i);
        for (n = 0; n < 20 && resp_i.second_exchange_word[0] !== req_o.second_exchange_word[0];
            n++) @(posedge clk_i);
        tb.chk({31'h0, n < 20}, 32'h1);
        repeat (4) @(posedge clk_i);
    endtask

    // Selects read data; a weight is only trusted when no error bit is set.
    task automatic fetch(input logic [4:0] sel, input logic [7:0] code,
        output logic [31:0] data, output logic clean);
        @(posedge clk_i);
        req_o.second_exchange_word[5:1] <= sel;
        req_o.first_exchange_word <= {8'h00, code, 16'h0000};
        repeat (8) @(posedge clk_i);
        data = resp_i.first_exchange_word;
        clean = resp_i.second_exchange_word[15:11] === 5'h00;
    endtask

    // A calibration is only requested while the device reports ready.
    task automatic start_cal(input logic [4:0] cmd, input logic [31:0] first, output logic went);
        logic [31:0] st;
        logic cl;
        fetch(RD_CAL, 8'h00, st, cl);
        went = st[7:0] === CAL_ST_READY;
        if (went) begin
            apply(cmd, first);
        end
    endtask
endmodule

// >>> dv/tb.sv
`timescale 1ns/1ps
// Bench for the command interpreter: PLC model on the exchange words, tasks on the software port.
module tb;
    import fbcmd_pkg::*;
    logic clk_i;
    logic nrst_i;
    exch_s plc_req;
    exch_s plc_resp;
    logic [4:0] weigh_err;
    cal_req_s cal_req;
    logic cal_done;
    logic cal_fail;
    logic [7:0] err_code;
    sw_req_s sw_req;
    logic [31:0] sw_rdata_o;
    logic irq;
    logic [31:0] d;
    logic ok;
    int i;
    int cyc;
    int fails;
    int n_tests;
    logic [7:0] codes [6] = '{EXP_FILTER, EXP_ZERO_RANGE, EXP_MOTION, EXP_PREACT,
        EXP_END_IND, EXP_MAX_FILL};

    fieldbus_param_cal u_dut (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .exch_in_i(plc_req),
        .exch_out_o(plc_resp),
        .weight_actual_i(32'h0000_0011),
        .weight_gross_i(32'h0000_1234),
        .weight_tare_i(32'h0000_0022),
        .weigh_err_i(weigh_err),
        .cal_req_o(cal_req),
        .cal_done_i(cal_done),
        .cal_fail_i(cal_fail),
        .cal_err_code_i(err_code),
        .sw_req_i(sw_req),
        .sw_rdata_o(sw_rdata_o),
        .irq_o(irq)
    );

    plc_model u_plc (
        .clk_i(clk_i),
        .resp_i(plc_resp),
        .req_o(plc_req)
    );

    always #50 clk_i = ~clk_i;

    // A hang ends the run through the normal report.
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            fails++;
            results();
        end
    end

    task automatic results();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic sw_wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_i);
        sw_req.addr <= a;
        sw_req.wdata <= v;
        sw_req.wr <= 1'b1;
        @(posedge clk_i);
        sw_req.wr <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe, so it is taken just after that edge.
    task automatic sw_rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk_i);
        sw_req.addr <= a;
        sw_req.rd <= 1'b1;
        @(posedge clk_i);
        sw_req.rd <= 1'b0;
        #1 v = sw_rdata_o;
    endtask

    // The start pulse lasts one cycle, so this runs beside the command that causes it.
    task automatic wait_start(input logic span, output logic [31:0] tw);
        int n;
        for (n = 0; n < 60 && (span ? cal_req.span_start : cal_req.zero_start) !== 1'b1; n++)
            @(posedge clk_i);
        chk({31'h0, n < 60}, 32'h1);
        tw = cal_req.test_weight;
    endtask

    task automatic pulse_front(input logic fail);
        @(posedge clk_i);
        cal_done <= !fail;
        cal_fail <= fail;
        @(posedge clk_i);
        cal_done <= 1'b0;
        cal_fail <= 1'b0;
    endtask

    initial begin
        clk_i = 1'b0;
        nrst_i = 1'b0;
        weigh_err = 5'h00;
        cal_done = 1'b0;
        cal_fail = 1'b0;
        err_code = 8'h5a;
        sw_req = '0;
        repeat (8) @(posedge clk_i);
        nrst_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        for (i = 0; i < 6; i++) begin
            u_plc.fetch(RD_EXPANDED, codes[i], d, ok);
            chk(d, PARAM_RESET[i*32 +: 32]);
            u_plc.apply(CMD_EXPANDED, {8'h00, codes[i], 16'h0100 + 16'(i)});
            u_plc.fetch(RD_EXPANDED, codes[i], d, ok);
            chk(d, 32'h0000_0100 + 32'(i));
        end
        sw_rd(REG_IRQ_STAT, d);
        chk(d, 32'h1);
        sw_rd(REG_IRQ_STAT, d);
        chk(d, 32'h0);
        sw_wr(REG_PARAM_SEL, 32'h5);
        sw_rd(REG_PARAM_DATA, d);
        chk(d, 32'h0000_0105);
        sw_rd(8'h20, d);
        chk(d, 32'h0);
        u_plc.apply(CMD_EXPANDED, {8'h00, 8'h41, 16'h7777});
        for (i = 0; i < 6; i++) begin
            u_plc.fetch(RD_EXPANDED, codes[i], d, ok);
            chk(d, 32'h0000_0100 + 32'(i));
        end
        sw_rd(REG_IRQ_STAT, d);
        chk(d, 32'h8);
        weigh_err <= 5'h15;
        u_plc.fetch(RD_GROSS, 8'h00, d, ok);
        chk({31'h0, ok}, 32'h0);
        weigh_err <= 5'h00;
        u_plc.fetch(RD_GROSS, 8'h00, d, ok);
        chk({31'h0, ok}, 32'h1);
        chk(d, 32'h0000_1234);
        u_plc.fetch(RD_TARE, 8'h00, d, ok);
        chk(d, 32'h0000_0022);
        u_plc.fetch(RD_ACTUAL, 8'h00, d, ok);
        chk(d, 32'h0000_0011);
        sw_wr(REG_IRQ_MASK, 32'h6);
        sw_rd(REG_IRQ_MASK, d);
        chk(d, 32'h6);
        fork
            u_plc.start_cal(CMD_ZERO_ADJ, 32'h0, ok);
            wait_start(1'b0, d);
        join
        chk({31'h0, ok}, 32'h1);
        u_plc.fetch(RD_CAL, 8'h00, d, ok);
        chk(d, 32'h3);
        pulse_front(1'b0);
        u_plc.fetch(RD_CAL, 8'h00, d, ok);
        chk(d, 32'h1);
        chk({31'h0, irq}, 32'h1);
        sw_rd(REG_IRQ_STAT, d);
        chk(d, 32'h2);
        chk({31'h0, irq}, 32'h0);
        fork
            u_plc.start_cal(CMD_SPAN_ADJ, 32'h0001_86a0, ok);
            wait_start(1'b1, d);
        join
        chk(d, 32'h0001_86a0);
        u_plc.fetch(RD_CAL, 8'h00, d, ok);
        chk(d, 32'h4);
        pulse_front(1'b1);
        u_plc.fetch(RD_CAL, 8'h00, d, ok);
        chk(d, 32'h5a09);
        sw_rd(REG_IRQ_STAT, d);
        chk(d, 32'h4);
        sw_rd(REG_CAL_STAT, d);
        chk(d, 32'h0000_5a09);
        sw_rd(REG_LAST_CMD, d);
        chk(d, 32'h0000_0102);
        u_plc.apply(5'h00, 32'h0);
        u_plc.fetch(RD_CAL, 8'h00, d, ok);
        chk(d, 32'h0000_5a01);
        sw_rd(REG_IRQ_STAT, d);
        chk(d, 32'h8);
        results();
    end
endmodule
